// ### exec_consts.svh
// constants for the flag branch and load/store execution block
// assumes the includer imports nothing; plain text macros only
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

`define PC_W            16
`define PC_RESET        16'h0000
`define PTR_X_LO        5'h1a
`define PTR_Y_LO        5'h1c
`define PTR_Z_LO        5'h1e
`define CYC_SHORT       2'h1
`define CYC_LONG        2'h2
`define WORDS_SHORT     16'h0001
`define WORDS_ABSOLUTE  16'h0002
`define REG_RESET       8'h00

`endif

// ### exec_pkg.sv
// types shared by the execution block and its address generator
// assumes exec_consts.svh is included by the modules that need numbers
package exec_pkg;

    // decoded operation classes handled by this block
    typedef enum logic [3:0] {
        OP_NOP                = 4'h0,
        OP_BRANCH_OVF_SET     = 4'h1,
        OP_BRANCH_OVF_CLEAR   = 4'h2,
        OP_BRANCH_IRQ_ON      = 4'h3,
        OP_BRANCH_IRQ_OFF     = 4'h4,
        OP_COPY_REG           = 4'h5,
        OP_COPY_REG_PAIR      = 4'h6,
        OP_LOAD_CONSTANT      = 4'h7,
        OP_LOAD_VIA_POINTER   = 4'h8,
        OP_LOAD_ABSOLUTE      = 4'h9,
        OP_WRITE_VIA_POINTER  = 4'ha
    } op_e;

    // pointer pair select
    typedef enum logic [1:0] {
        PTR_X = 2'h0,
        PTR_Y = 2'h1,
        PTR_Z = 2'h2
    } ptr_e;

    // pointer addressing mode; offset is the load_offset / displacement form
    typedef enum logic [1:0] {
        MODE_PLAIN    = 2'h0,
        MODE_POST_INC = 2'h1,
        MODE_PRE_DEC  = 2'h2,
        MODE_OFFSET   = 2'h3
    } mode_e;

    // sequencer states, gray along idle -> mem -> idle and idle -> branch
    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_MEM    = 2'h1,
        ST_BRANCH = 2'h2
    } state_e;

    // one decoded instruction as handed over by the decoder
    typedef struct packed {
        op_e         op;
        logic [4:0]  rd;
        logic [4:0]  rr;
        ptr_e        ptr;
        mode_e       mode;
        logic [5:0]  disp;
        logic [6:0]  offset;
        logic [15:0] imm;
    } instr_s;

    // data memory request, asynchronous read memory assumed
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        re;
        logic        we;
    } dmem_req_s;

endpackage : exec_pkg

// ### ptr_addr_gen.sv
// address generator for pointer, displacement and direct accesses
// assumes the pointer value is read from the register file this cycle
`timescale 1ns/1ps
`include "exec_consts.svh"

module ptr_addr_gen
    import exec_pkg::*;
(
    input  wire logic [15:0] ptr_val,    // current pointer pair value
    input  wire mode_e       mode,       // addressing mode
    input  wire ptr_e        ptr,        // which pair
    input  wire logic [5:0]  disp,       // unsigned displacement
    input  wire logic [15:0] direct,     // absolute address
    input  wire logic        use_direct, // direct access select
    output logic      [15:0] addr,       // address for the access
    output logic      [15:0] ptr_new,    // pointer value after access
    output logic             ptr_we      // pointer must be written back
);

    ////////////////////////////////////////////////////////////////////
    // address and pointer update
    always_comb begin
        addr    = ptr_val;
        ptr_new = ptr_val;
        ptr_we  = 1'b0;
        if (use_direct) begin
            addr = direct;
        end else begin
            case (mode)
                MODE_POST_INC: begin
                    ptr_new = ptr_val + `WORDS_SHORT;
                    ptr_we  = 1'b1;
                end
                MODE_PRE_DEC: begin
                    ptr_new = ptr_val - `WORDS_SHORT;
                    addr    = ptr_new;
                    ptr_we  = 1'b1;
                end
                MODE_OFFSET: begin
                    if (ptr != PTR_X) begin
                        addr = ptr_val + {10'h000, disp};
                    end
                end
                default: begin
                    addr = ptr_val; // plain form, pointer untouched
                end
            endcase
        end
    end

endmodule : ptr_addr_gen

// ### flag_branch_ldst_exec.sv
// execution unit for flag branches and data transfers, with its own
// 32 x 8 register file and program counter
// assumes an asynchronous-read data memory and flags from the same clock
`timescale 1ns/1ps
`include "exec_consts.svh"

module flag_branch_ldst_exec
    import exec_pkg::*;
(
    input  wire logic              SYS_CLK,     // core clock, 25 MHz
    input  wire logic              RST,         // async reset, active high
    input  wire logic              INSTR_VALID, // decoded instruction offered
    input  wire instr_s            INSTR,       // decoded instruction
    output logic                   INSTR_READY, // block can take one now
    input  wire logic              FLAG_OVF,    // overflow flag, core domain
    input  wire logic              FLAG_IRQ_EN, // global interrupt enable
    output dmem_req_s              DMEM_REQ,    // data memory request
    input  wire logic [7:0]        DMEM_RDATA,  // read data, same cycle
    output logic [`PC_W-1:0]       PC_OUT,      // program counter
    output logic                   RETIRE,      // instruction completes
    output logic                   FLAGS_WE,    // status flag write strobe
    input  wire logic [4:0]        DBG_ADDR,    // register file peek index
    output logic [7:0]             DBG_DATA     // register file peek data
);

    ////////////////////////////////////////////////////////////////////
    // state
    state_e           state_reg, state_next;     // sequencer
    logic [15:0]      pc_reg, pc_next;           // program counter
    logic [7:0]       regs_reg [32];             // register file
    logic [7:0]       regs_next [32];            // its next contents
    dmem_req_s        mem_reg, mem_next;         // registered memory request
    logic [4:0]       dst_reg, dst_next;         // load destination
    logic             accept;                    // instruction taken
    logic             br_cond;                   // branch condition true
    logic [15:0]      br_target;                 // taken target
    logic [4:0]       ptr_lo;                    // low index of pointer pair
    logic [15:0]      ptr_val;                   // pointer pair value
    logic [15:0]      acc_addr;                  // access address
    logic [15:0]      ptr_new;                   // updated pointer
    logic             ptr_we;                    // pointer write back
    logic             is_mem;                    // two-cycle memory op

    // ready only in idle; the second cycle of a long op blocks the decoder
    assign INSTR_READY = (state_reg == ST_IDLE);
    assign accept      = INSTR_READY && INSTR_VALID;
    assign RETIRE      = (accept && !is_mem && !br_cond)
                       || (state_reg != ST_IDLE);
    assign FLAGS_WE    = 1'b0;
    assign PC_OUT      = pc_reg;
    assign DMEM_REQ    = mem_reg;
    assign DBG_DATA    = regs_reg[DBG_ADDR];

    ////////////////////////////////////////////////////////////////////
    // branch condition and target
    always_comb begin
        case (INSTR.op)
            OP_BRANCH_OVF_SET:   br_cond = FLAG_OVF;
            OP_BRANCH_OVF_CLEAR: br_cond = !FLAG_OVF;
            OP_BRANCH_IRQ_ON:    br_cond = FLAG_IRQ_EN;
            OP_BRANCH_IRQ_OFF:   br_cond = !FLAG_IRQ_EN;
            default:             br_cond = 1'b0;
        endcase
        // sign-extended offset plus one word
        br_target = pc_reg + {{9{INSTR.offset[6]}}, INSTR.offset} + `WORDS_SHORT;
    end

    ////////////////////////////////////////////////////////////////////
    // pointer selection; value 3 of the select falls to the third pair
    always_comb begin
        case (INSTR.ptr)
            PTR_X:   ptr_lo = `PTR_X_LO;
            PTR_Y:   ptr_lo = `PTR_Y_LO;
            default: ptr_lo = `PTR_Z_LO;
        endcase
        ptr_val = {regs_reg[ptr_lo + 5'h01], regs_reg[ptr_lo]};
        is_mem  = (INSTR.op == OP_LOAD_VIA_POINTER)
               || (INSTR.op == OP_LOAD_ABSOLUTE)
               || (INSTR.op == OP_WRITE_VIA_POINTER);
    end

    ptr_addr_gen u_addr (
        .ptr_val    (ptr_val),
        .mode       (INSTR.mode),
        .ptr        (INSTR.ptr),
        .disp       (INSTR.disp),
        .direct     (INSTR.imm),
        .use_direct (INSTR.op == OP_LOAD_ABSOLUTE),
        .addr       (acc_addr),
        .ptr_new    (ptr_new),
        .ptr_we     (ptr_we)
    );

    ////////////////////////////////////////////////////////////////////
    // next state, pc, memory request and register file
    always_comb begin
        state_next = state_reg;
        pc_next    = pc_reg;
        mem_next   = '0;
        dst_next   = dst_reg;
        for (int i = 0; i < 32; i++) begin
            regs_next[i] = regs_reg[i];
        end
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    pc_next = pc_reg + `WORDS_SHORT;
                    case (INSTR.op)
                        OP_BRANCH_OVF_SET, OP_BRANCH_OVF_CLEAR,
                        OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF: begin
                            // a taken branch spends a second cycle
                            if (br_cond) begin
                                pc_next    = br_target;
                                state_next = ST_BRANCH;
                            end
                        end
                        OP_COPY_REG: begin
                            regs_next[INSTR.rd] = regs_reg[INSTR.rr];
                        end
                        OP_COPY_REG_PAIR: begin
                            regs_next[{INSTR.rd[4:1], 1'b0}] =
                                regs_reg[{INSTR.rr[4:1], 1'b0}];
                            regs_next[{INSTR.rd[4:1], 1'b1}] =
                                regs_reg[{INSTR.rr[4:1], 1'b1}];
                        end
                        OP_LOAD_CONSTANT: begin
                            regs_next[INSTR.rd] = INSTR.imm[7:0];
                        end
                        OP_LOAD_ABSOLUTE: begin
                            pc_next       = pc_reg + `WORDS_ABSOLUTE;
                            mem_next.addr = acc_addr;
                            mem_next.re   = 1'b1;
                            dst_next      = INSTR.rd;
                            state_next    = ST_MEM;
                        end
                        OP_LOAD_VIA_POINTER: begin
                            mem_next.addr = acc_addr;
                            mem_next.re   = 1'b1;
                            dst_next      = INSTR.rd;
                            state_next    = ST_MEM;
                            if (ptr_we) begin
                                regs_next[ptr_lo]         = ptr_new[7:0];
                                regs_next[ptr_lo + 5'h01] = ptr_new[15:8];
                            end
                        end
                        OP_WRITE_VIA_POINTER: begin
                            mem_next.addr  = acc_addr;
                            mem_next.wdata = regs_reg[INSTR.rr];
                            mem_next.we    = 1'b1;
                            state_next     = ST_MEM;
                            if (ptr_we) begin
                                regs_next[ptr_lo]         = ptr_new[7:0];
                                regs_next[ptr_lo + 5'h01] = ptr_new[15:8];
                            end
                        end
                        default: begin
                            pc_next = pc_reg + `WORDS_SHORT; // no-op
                        end
                    endcase
                end
            end
            // second cycle of a load: capture the returned byte
            ST_MEM: begin
                if (mem_reg.re) begin
                    regs_next[dst_reg] = DMEM_RDATA;
                end
                state_next = ST_IDLE;
            end
            // second cycle of a taken branch: pipeline refill
            ST_BRANCH: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // registers; a pointer bump lands at the accept edge, but the access
    // address was already formed from the old value (the decremented one for pre-decrement), so order is kept
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            pc_reg    <= `PC_RESET;
            mem_reg   <= '0;
            dst_reg   <= 5'h00;
            for (int i = 0; i < 32; i++) begin
                regs_reg[i] <= `REG_RESET;
            end
        end else begin
            state_reg <= state_next;
            pc_reg    <= pc_next;
            mem_reg   <= mem_next;
            dst_reg   <= dst_next;
            for (int i = 0; i < 32; i++) begin
                regs_reg[i] <= regs_next[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    a_ovf_set_jump: assert property (
        accept && INSTR.op == OP_BRANCH_OVF_SET && FLAG_OVF
        |=> PC_OUT == $past(br_target) && state_reg == ST_BRANCH ##1 INSTR_READY)
        else $error("overflow-set branch wrong target or length");

    a_ovf_clear_fall: assert property (
        accept && INSTR.op == OP_BRANCH_OVF_CLEAR && FLAG_OVF
        |=> PC_OUT == $past(pc_reg) + 16'h0001 && INSTR_READY)
        else $error("overflow-clear branch did not fall through");

    a_irq_on_jump: assert property (
        accept && INSTR.op == OP_BRANCH_IRQ_ON
        |=> PC_OUT == ($past(FLAG_IRQ_EN) ? $past(br_target) : $past(pc_reg) + 16'h0001))
        else $error("irq-enabled branch wrong pc");

    a_irq_off_jump: assert property (
        accept && INSTR.op == OP_BRANCH_IRQ_OFF && !FLAG_IRQ_EN
        |=> !INSTR_READY ##1 INSTR_READY)
        else $error("irq-disabled taken branch not two cycles");

    a_post_inc_load: assert property (
        accept && INSTR.op == OP_LOAD_VIA_POINTER && INSTR.mode == MODE_POST_INC
        |=> DMEM_REQ.re && DMEM_REQ.addr == $past(ptr_val)
            && {regs_reg[$past(ptr_lo) + 5'h01], regs_reg[$past(ptr_lo)]}
               == $past(ptr_val) + 16'h0001)
        else $error("post-increment load order wrong");

    a_pre_dec_load: assert property (
        accept && INSTR.op == OP_LOAD_VIA_POINTER && INSTR.mode == MODE_PRE_DEC
        |=> DMEM_REQ.addr == $past(ptr_val) - 16'h0001)
        else $error("pre-decrement load used stale address");

    a_abs_load_data: assert property (
        accept && INSTR.op == OP_LOAD_ABSOLUTE
        |=> DMEM_REQ.addr == $past(INSTR.imm) ##1
            regs_reg[$past(INSTR.rd, 2)] == $past(DMEM_RDATA) && INSTR_READY)
        else $error("absolute load missed data");

    a_offset_store: assert property (
        accept && INSTR.op == OP_WRITE_VIA_POINTER && INSTR.mode == MODE_OFFSET
        && INSTR.ptr != PTR_X
        |=> DMEM_REQ.we && DMEM_REQ.addr == $past(ptr_val) + {10'h000, $past(INSTR.disp)}
            && {regs_reg[$past(ptr_lo) + 5'h01], regs_reg[$past(ptr_lo)]} == $past(ptr_val))
        else $error("displacement store wrong address or pointer moved");

    a_copy_one_cycle: assert property (
        accept && INSTR.op == OP_COPY_REG
        |-> RETIRE ##1 regs_reg[$past(INSTR.rd)] == $past(regs_reg[INSTR.rr]) && INSTR_READY)
        else $error("register copy not single cycle");

    c_taken_branch: cover property (accept && br_cond);
    c_post_inc_store: cover property (accept && INSTR.op == OP_WRITE_VIA_POINTER
                                      && INSTR.mode == MODE_POST_INC);
    c_abs_load: cover property (accept && INSTR.op == OP_LOAD_ABSOLUTE);

endmodule : flag_branch_ldst_exec

// ### dmem_model.sv
// data memory model facing the execution block
// assumes registered requests from the core clock domain
`timescale 1ns/1ps

module dmem_model
    import exec_pkg::*;
(
    input  wire logic      SYS_CLK, // core clock
    input  wire dmem_req_s REQ,     // request from the block
    output logic [7:0]     RDATA    // read data, same cycle
);
    logic [7:0] mem [0:255]; // 256 bytes only: tests stay low
    logic [7:0] last_reg;    // byte returned by the last read

    ////////////////////////////////////////////////////////////
    // known fill so every load has a predictable answer
    initial begin
        for (int a = 0; a < 256; a++) begin
            mem[a] = 8'(a) ^ 8'h5a;
        end
        last_reg = 8'h00;
    end

    // writes land at the edge that closes the store cycle
    always @(posedge SYS_CLK) begin
        if (REQ.we) begin
            mem[REQ.addr[7:0]] <= REQ.wdata;
        end
        if (REQ.re) begin
            last_reg <= RDATA;
        end
    end

    // released bus shows the inverse, so a late sample is caught
    always_comb RDATA = REQ.re ? mem[REQ.addr[7:0]] : ~last_reg;
endmodule : dmem_model

// ### flag_branch_and_load_store_exec_bench.sv
// self-checking bench for the flag branch and load/store block
// assumes an asynchronous-read memory model on the far side
`timescale 1ns/1ps

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end

module flag_branch_and_load_store_exec_bench
    import exec_pkg::*;
;
    logic        SYS_CLK = 1'b0;   // core clock
    logic        RST = 1'b1;       // reset, active high
    logic        INSTR_VALID = 1'b0; // offer strobe
    instr_s      INSTR = '0;       // offered instruction
    logic        INSTR_READY;      // block ready
    logic        FLAG_OVF = 1'b0;  // overflow flag
    logic        FLAG_IRQ_EN = 1'b0; // interrupt enable
    dmem_req_s   DMEM_REQ;         // memory request
    logic [7:0]  DMEM_RDATA;       // memory data
    logic [15:0] PC_OUT;           // program counter
    logic        RETIRE;           // completion pulse
    logic        FLAGS_WE;         // flag write strobe
    logic [4:0]  DBG_ADDR = 5'd0;  // register peek index
    logic [7:0]  DBG_DATA;         // register peek data
    int          bad_count = 0;    // mismatches
    int          n_checks = 0;     // comparisons
    logic [15:0] pc = 16'h0000;    // expected program counter

    always #20 SYS_CLK = ~SYS_CLK;

    flag_branch_ldst_exec dut (.SYS_CLK(SYS_CLK), .RST(RST), .INSTR_VALID(INSTR_VALID),
        .INSTR(INSTR), .INSTR_READY(INSTR_READY), .FLAG_OVF(FLAG_OVF),
        .FLAG_IRQ_EN(FLAG_IRQ_EN), .DMEM_REQ(DMEM_REQ), .DMEM_RDATA(DMEM_RDATA),
        .PC_OUT(PC_OUT), .RETIRE(RETIRE), .FLAGS_WE(FLAGS_WE), .DBG_ADDR(DBG_ADDR),
        .DBG_DATA(DBG_DATA));

    dmem_model mem (.SYS_CLK(SYS_CLK), .REQ(DMEM_REQ), .RDATA(DMEM_RDATA));

    ////////////////////////////////////////////////////////////
    // memory fill pattern as the far side holds it
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction : pat

    // one decoded instruction; v feeds imm, disp and offset
    function automatic instr_s mk(input op_e op, input logic [4:0] rd,
        input logic [4:0] rr, input ptr_e p, input mode_e m, input logic [15:0] v);
        instr_s t;
        t = '0;
        t.op = op;
        t.rd = rd;
        t.rr = rr;
        t.ptr = p;
        t.mode = m;
        t.disp = v[5:0];
        t.offset = v[6:0];
        t.imm = v;
        return t;
    endfunction : mk

    // offer at edge+1, judge both cycles; valid stays up after
    // a one-cycle op so the next one follows back to back
    task automatic exec(input instr_s i, input int cyc, input logic [15:0] pc_e,
        input logic re, input logic we, input logic [15:0] ad, input logic [7:0] wd);
        INSTR_VALID = 1'b1;
        INSTR = i;
        #2;
        `CHK("ready", 1'b1, INSTR_READY)
        `CHK("retire c0", (cyc == 1), RETIRE)
        `CHK("flags_we", 1'b0, FLAGS_WE)
        @(posedge SYS_CLK);
        #1;
        `CHK("pc", pc_e, PC_OUT)
        `CHK("re", re, DMEM_REQ.re)
        `CHK("we", we, DMEM_REQ.we)
        if (re | we) `CHK("addr", ad, DMEM_REQ.addr)
        if (we) `CHK("wdata", wd, DMEM_REQ.wdata)
        if (cyc == 2) begin
            INSTR_VALID = 1'b0;
            #1;
            `CHK("ready c1", 1'b0, INSTR_READY)
            `CHK("retire c1", 1'b1, RETIRE)
            @(posedge SYS_CLK);
            #1;
        end
    endtask : exec

    // immediate load, one cycle
    task automatic ldc(input logic [4:0] r, input logic [7:0] v);
        pc = pc + 16'h1;
        exec(mk(OP_LOAD_CONSTANT, r, 5'd0, PTR_X, MODE_PLAIN, {8'h00, v}), 1, pc,
            1'b0, 1'b0, 16'h0, 8'h0);
    endtask : ldc

    // memory op of n program words; w selects store
    task automatic mop(input instr_s i, input logic [15:0] n, input logic w,
        input logic [15:0] ad, input logic [7:0] wd);
        pc = pc + n;
        exec(i, 2, pc, ~w, w, ad, wd);
    endtask : mop

    // peek a register with the offer dropped
    task automatic chk_reg(input logic [4:0] r, input logic [7:0] e);
        INSTR_VALID = 1'b0;
        DBG_ADDR = r;
        #2;
        `CHK("reg", e, DBG_DATA)
        @(posedge SYS_CLK);
        #1;
    endtask : chk_reg

    ////////////////////////////////////////////////////////////
    // every branch kind, taken and not; overflow-set and irq-on forward, overflow-clear and irq-off backward
    task automatic t_branches();
        op_e op;
        logic [6:0] off;
        logic fl;
        logic tk;
        for (int k = 0; k < 8; k++) begin
            op = op_e'(k / 2 + 1);
            fl = k[0];
            off = k[1] ? 7'h7c : 7'h05;
            FLAG_OVF = fl;
            FLAG_IRQ_EN = ~fl;
            tk = (op == OP_BRANCH_OVF_SET || op == OP_BRANCH_IRQ_OFF) ? fl : ~fl;
            pc = tk ? pc + {{9{off[6]}}, off} + 16'h1 : pc + 16'h1;
            exec(mk(op, 5'd0, 5'd0, PTR_X, MODE_PLAIN, {9'h0, off}), tk ? 2 : 1, pc,
                1'b0, 1'b0, 16'h0, 8'h0);
        end
        INSTR_VALID = 1'b0;
        $display("branch test done");
    endtask : t_branches

    // copies back to back; pair copy forces even indices
    task automatic t_copies();
        ldc(5'd16, 8'ha5);
        ldc(5'd17, 8'h3c);
        pc = pc + 16'h1;
        exec(mk(OP_COPY_REG, 5'd3, 5'd16, PTR_X, MODE_PLAIN, 16'h0), 1, pc,
            1'b0, 1'b0, 16'h0, 8'h0);
        pc = pc + 16'h1;
        exec(mk(OP_COPY_REG_PAIR, 5'd5, 5'd17, PTR_X, MODE_PLAIN, 16'h0), 1, pc,
            1'b0, 1'b0, 16'h0, 8'h0);
        chk_reg(5'd3, 8'ha5);
        chk_reg(5'd4, 8'ha5);
        chk_reg(5'd5, 8'h3c);
        $display("copy test done");
    endtask : t_copies

    // pointer, displacement and absolute accesses; stores are read back
    // through other address forms so a lost write cannot hide
    task automatic t_memory();
        ldc(5'd26, 8'h10);
        ldc(5'd27, 8'h00);
        ldc(5'd28, 8'h40);
        ldc(5'd29, 8'h00);
        ldc(5'd30, 8'h80);
        ldc(5'd31, 8'h00);
        mop(mk(OP_LOAD_VIA_POINTER, 5'd1, 5'd0, PTR_X, MODE_POST_INC, 16'h0), 16'h1, 1'b0,
            16'h0010, 8'h0);
        chk_reg(5'd1, pat(16'h0010));
        chk_reg(5'd26, 8'h11);
        mop(mk(OP_LOAD_VIA_POINTER, 5'd2, 5'd0, PTR_Y, MODE_PRE_DEC, 16'h0), 16'h1, 1'b0,
            16'h003f, 8'h0);
        chk_reg(5'd2, pat(16'h003f));
        chk_reg(5'd28, 8'h3f);
        mop(mk(OP_LOAD_VIA_POINTER, 5'd3, 5'd0, PTR_Z, MODE_OFFSET, 16'h5), 16'h1, 1'b0,
            16'h0085, 8'h0);
        chk_reg(5'd3, pat(16'h0085));
        chk_reg(5'd30, 8'h80);
        mop(mk(OP_LOAD_ABSOLUTE, 5'd4, 5'd0, PTR_X, MODE_PLAIN, 16'h00c3), 16'h2, 1'b0,
            16'h00c3, 8'h0);
        chk_reg(5'd4, pat(16'h00c3));
        mop(mk(OP_WRITE_VIA_POINTER, 5'd0, 5'd16, PTR_X, MODE_POST_INC, 16'h0), 16'h1, 1'b1,
            16'h0011, 8'ha5);
        chk_reg(5'd26, 8'h12);
        mop(mk(OP_WRITE_VIA_POINTER, 5'd0, 5'd17, PTR_Y, MODE_PRE_DEC, 16'h0), 16'h1, 1'b1,
            16'h003e, 8'h3c);
        chk_reg(5'd28, 8'h3e);
        mop(mk(OP_WRITE_VIA_POINTER, 5'd0, 5'd16, PTR_Z, MODE_OFFSET, 16'h2), 16'h1, 1'b1,
            16'h0082, 8'ha5);
        chk_reg(5'd30, 8'h80);
        mop(mk(OP_LOAD_VIA_POINTER, 5'd6, 5'd0, PTR_Y, MODE_PLAIN, 16'h0), 16'h1, 1'b0,
            16'h003e, 8'h0);
        chk_reg(5'd6, 8'h3c);
        chk_reg(5'd28, 8'h3e);
        mop(mk(OP_LOAD_ABSOLUTE, 5'd7, 5'd0, PTR_X, MODE_PLAIN, 16'h0082), 16'h2, 1'b0,
            16'h0082, 8'h0);
        chk_reg(5'd7, 8'ha5);
        mop(mk(OP_LOAD_ABSOLUTE, 5'd8, 5'd0, PTR_X, MODE_PLAIN, 16'h0011), 16'h2, 1'b0,
            16'h0011, 8'h0);
        chk_reg(5'd8, 8'ha5);
        $display("memory test done");
    endtask : t_memory

    // counts, verdict and end of run; the only exit of the bench
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////
    // reset for five edges, released just after an edge like all stimulus
    initial begin
        repeat (5) @(posedge SYS_CLK);
        #1;
        RST = 1'b0;
        t_branches();
        t_copies();
        t_memory();
        report_and_stop();
    end

    // watchdog: the tests need well under a hundred cycles, allow 500
    initial begin
        #20000;
        bad_count++;
        $display("Error watchdog expected done seen timeout");
        report_and_stop();
    end
endmodule : flag_branch_and_load_store_exec_bench
